// ### rtl/i2cs_filt.sv
// Two-flop synchroniser with selectable debounce for one bus line
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_regs.svh"
module i2cs_filt import i2cs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic line_i,
  input wire logic [1:0] sel_i,
  output logic level_o
);
  i2cs_filt_state_t q;
  i2cs_filt_state_t d;
  logic [2:0] need;

  // Settle time 0, 2 or 4 clocks; first flop feeds only the second
  always_comb begin
    d = q;
    need = (sel_i == 2'h0) ? `I2CS_DEB_NONE :
           (sel_i == 2'h1) ? `I2CS_DEB_SHORT : `I2CS_DEB_LONG;
    d.s1 = line_i;
    d.s2 = q.s1;
    if (q.s2 == q.level) begin
      d.cnt = 3'h0;
    end else if (need == 3'h0 || (q.cnt + 3'h1) >= need) begin
      d.level = q.s2;
      d.cnt = 3'h0;
    end else begin
      d.cnt = q.cnt + 3'h1;
    end
  end

  // Idle bus is high, so both flops and the level reset high; the count resets to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{s1: 1'b1, s2: 1'b1, cnt: 3'h0, level: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign level_o = q.level;
endmodule : i2cs_filt
`default_nettype wire

// ### rtl/i2cs_pkg.sv
// Types shared by the two-wire slave and its line filter
`default_nettype none
package i2cs_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_AACK = 8'h04,
    ST_RX = 8'h08,
    ST_RACK = 8'h10,
    ST_TX = 8'h20,
    ST_TACK = 8'h40,
    ST_SKIP = 8'h80
  } i2cs_state_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] deb;
    logic en;
    logic incomplete;
  } i2cs_ctrl0_t;

  // Bit order matches the status/control register layout
  typedef struct packed {
    logic transfer_complete_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic direction_select;
    logic ack_to_send;
    logic master_read_write_flag;
    logic wake_en;
    logic ack_received_flag;
  } i2cs_stat_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cs_lines_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } i2cs_drive_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic [2:0] cnt;
    logic level;
  } i2cs_filt_state_t;

  typedef struct packed {
    i2cs_state_t st;
    i2cs_ctrl0_t ctrl0;
    i2cs_stat_t stat;
    logic [7:0] data;
    logic [7:0] own;
    logic irq_en;
    logic [7:0] sh;
    logic [3:0] cnt;
    i2cs_lines_t prev;
    i2cs_drive_t drv;
    logic irq;
    logic wake;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } i2cs_top_state_t;
endpackage : i2cs_pkg
`default_nettype wire

// ### rtl/i2cs_regs.svh
// Register offsets, reset values and protocol counts of the two-wire slave
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH
`define I2CS_OFF_CTRL0 8'h00
`define I2CS_OFF_STAT 8'h04
`define I2CS_OFF_DATA 8'h08
`define I2CS_OFF_OWN 8'h0c
`define I2CS_OFF_IRQEN 8'h10
`define I2CS_CTRL0_RST 7'h70
`define I2CS_STAT_RST 8'h81
`define I2CS_OWN_RST 8'h00
`define I2CS_DATA_RST 8'h00
`define I2CS_MODE_I2C 3'h6
`define I2CS_DEB_NONE 3'h0
`define I2CS_DEB_SHORT 3'h2
`define I2CS_DEB_LONG 3'h4
`define I2CS_BITS 4'h8
`define I2CS_STAT_HTX_POS 4
`define I2CS_STAT_ACK_TO_SEND_POS 3
`define I2CS_STAT_SRW_POS 2
`define I2CS_STAT_WAKE_POS 1
`define I2CS_IRQEN_POS 0
`endif

// ### rtl/i2cs_top.sv
// Two-wire slave: status/control flags, protocol engine and APB registers
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_regs.svh"
// Functional notes
// - Transfer-complete flag low during a byte, set with interrupt after 8.
// - Address-match flag set on own address, low otherwise.
// - Bus-busy flag set on START, cleared on STOP.
// - Direction bit 0 makes the slave receive, 1 makes it transmit.
// - After 8 received bits, drive ack-to-send on the 9th clock.
// - Eighth bit after START lands in the read/write flag.
// - With wake-up enable set, an address match wakes the system.
// - After 8 sent bits, sample the 9th-clock level into ack-received.
// - Transmit while acknowledged; on no-ack release data line for STOP.
// - First seven bits after START, MSB first, are compared as address.
// - One interrupt for match, byte done, timeout; software sorts source. No timeout source is detected here.
// - On match, drive a low acknowledge as the 9th bit.
// - START is data falling while clock stays high.
// - After match, hold clock low until data write (tx) or read (rx).
// - Own address lives in the upper seven bits of its register.
// - Clock line debounce of none, 2 or 4 system clocks.
module i2cs_top import i2cs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o,
  output logic wake_o
);
  i2cs_top_state_t q;
  i2cs_top_state_t d;
  i2cs_lines_t lines;
  logic scl_f;
  logic sda_f;
  logic active, start_ev, stop_ev, scl_rise, scl_fall;
  logic setup, acc, wr_data, rd_data, rel_ev, match;
  logic addr_done, rx_done, tack_rise, tack_fall;

  // Clock line gets the selected debounce; data line is only synchronised
  i2cs_filt u_scl_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(scl_i),
    .sel_i(q.ctrl0.deb),
    .level_o(scl_f)
  );
  i2cs_filt u_sda_filt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .line_i(sda_i),
    .sel_i(2'h0),
    .level_o(sda_f)
  );
  assign lines = '{scl: scl_f, sda: sda_f};

  // Bus conditions from the sampled line levels
  assign active = q.ctrl0.en && (q.ctrl0.mode == `I2CS_MODE_I2C);
  assign scl_rise = lines.scl && !q.prev.scl;
  assign scl_fall = !lines.scl && q.prev.scl;
  assign start_ev = active && q.prev.sda && !lines.sda &&
                    lines.scl && q.prev.scl;
  assign stop_ev = active && !q.prev.sda && lines.sda &&
                   lines.scl && q.prev.scl;

  // APB phases; side effects only in the completing access cycle
  assign setup = psel_i && !penable_i && !q.pready;
  assign acc = psel_i && penable_i && q.pready && !q.pslverr;
  assign wr_data = acc && pwrite_i && paddr_i == `I2CS_OFF_DATA;
  assign rd_data = acc && !pwrite_i && paddr_i == `I2CS_OFF_DATA;
  assign rel_ev = q.stat.direction_select ? wr_data : rd_data;

  // Protocol milestones, also watched by the checks below
  assign match = q.sh[7:1] == q.own[7:1];
  assign addr_done = active && !start_ev && !stop_ev && q.st == ST_ADDR &&
                     scl_fall && q.cnt == `I2CS_BITS;
  assign rx_done = active && !start_ev && !stop_ev && q.st == ST_RX &&
                   !q.drv.scl_oe && scl_fall && q.cnt == `I2CS_BITS;
  assign tack_rise = active && !start_ev && !stop_ev &&
                     q.st == ST_TACK && scl_rise;
  assign tack_fall = active && !start_ev && !stop_ev &&
                     q.st == ST_TACK && scl_fall;

  always_comb begin
    d = q;
    d.prev = lines;
    d.irq = 1'b0;
    d.wake = 1'b0;
    d.pready = 1'b0;
    d.pslverr = 1'b0;
    // Registered answer: pready rises in the first access cycle
    if (setup) begin
      d.pready = 1'b1;
      d.prdata = 32'h0;
      case (paddr_i)
        `I2CS_OFF_CTRL0: d.prdata[7:0] = {q.ctrl0.mode, 1'b0, q.ctrl0.deb,
                                          q.ctrl0.en, q.ctrl0.incomplete};
        `I2CS_OFF_STAT: d.prdata[7:0] = q.stat;
        `I2CS_OFF_DATA: d.prdata[7:0] = q.data;
        `I2CS_OFF_OWN: d.prdata[7:0] = q.own;
        `I2CS_OFF_IRQEN: d.prdata[0] = q.irq_en;
        default: d.pslverr = 1'b1;
      endcase
    end
    // Software writes first so hardware flag updates below win
    if (acc && pwrite_i) begin
      case (paddr_i)
        `I2CS_OFF_CTRL0: d.ctrl0 = {pwdata_i[7:5], pwdata_i[3:0]};
        `I2CS_OFF_STAT: begin
          d.stat.direction_select = pwdata_i[`I2CS_STAT_HTX_POS];
          d.stat.ack_to_send = pwdata_i[`I2CS_STAT_ACK_TO_SEND_POS];
          d.stat.master_read_write_flag = pwdata_i[`I2CS_STAT_SRW_POS];
          d.stat.wake_en = pwdata_i[`I2CS_STAT_WAKE_POS];
        end
        `I2CS_OFF_DATA: d.data = pwdata_i[7:0];
        `I2CS_OFF_OWN: d.own = pwdata_i[7:0];
        `I2CS_OFF_IRQEN: d.irq_en = pwdata_i[`I2CS_IRQEN_POS];
        default: d.own = d.own;
      endcase
    end
    if (!active) begin
      // Disabled: flags back to defaults, control bits kept, wire free
      d.st = ST_IDLE;
      d.stat.transfer_complete_flag = 1'b1;
      d.stat.address_match_flag = 1'b0;
      d.stat.bus_busy_flag = 1'b0;
      d.stat.master_read_write_flag = 1'b0;
      d.stat.ack_received_flag = 1'b1;
      d.drv = '0;
    end else if (start_ev) begin
      // Also covers a repeated START in mid-transfer
      d.stat.bus_busy_flag = 1'b1;
      d.stat.address_match_flag = 1'b0;
      d.st = ST_ADDR;
      d.cnt = 4'h0;
      d.drv = '0;
    end else if (stop_ev) begin
      d.stat.bus_busy_flag = 1'b0;
      d.st = ST_IDLE;
      d.drv = '0;
    end else if (q.drv.scl_oe) begin
      // Clock held low; released by the data access matching direction
      if (rel_ev) begin
        d.drv.scl_oe = 1'b0;
        d.cnt = 4'h0;
        d.stat.transfer_complete_flag = 1'b0;
        if (q.stat.direction_select) begin
          d.st = ST_TX;
          d.sh = wr_data ? pwdata_i[7:0] : q.data;
          d.drv.sda_oe = !d.sh[7];
        end else begin
          d.st = ST_RX;
        end
      end
    end else begin
      case (q.st)
        ST_ADDR: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], lines.sda};
            d.cnt = q.cnt + 4'h1;
          end else if (addr_done) begin
            if (match) begin
              d.stat.address_match_flag = 1'b1;
              d.stat.master_read_write_flag = q.sh[0];
              d.stat.transfer_complete_flag = 1'b1;
              d.irq = q.irq_en;
              d.wake = q.stat.wake_en;
              d.drv.sda_oe = 1'b1;
              d.st = ST_AACK;
            end else begin
              d.stat.address_match_flag = 1'b0;
              d.st = ST_SKIP;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            d.drv.sda_oe = 1'b0;
            d.drv.scl_oe = 1'b1;
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            d.sh = {q.sh[6:0], lines.sda};
            d.cnt = q.cnt + 4'h1;
          end else if (rx_done) begin
            d.data = q.sh;
            d.stat.transfer_complete_flag = 1'b1;
            d.irq = q.irq_en;
            d.drv.sda_oe = !q.stat.ack_to_send;
            d.st = ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            // Stretch each byte too, so the data register is never overrun
            d.drv.sda_oe = 1'b0;
            d.drv.scl_oe = 1'b1;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == `I2CS_BITS) begin
              d.drv.sda_oe = 1'b0;
              d.st = ST_TACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.drv.sda_oe = !q.sh[6];
            end
          end
        end
        ST_TACK: begin
          if (tack_rise) begin
            d.stat.ack_received_flag = lines.sda;
            d.stat.transfer_complete_flag = 1'b1;
            d.irq = q.irq_en;
          end else if (tack_fall) begin
            if (q.stat.ack_received_flag) begin
              d.st = ST_SKIP;
            end else begin
              d.drv.scl_oe = 1'b1;
            end
          end
        end
        default: d.st = q.st;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl0 <= `I2CS_CTRL0_RST;
      q.stat <= `I2CS_STAT_RST;
      q.own <= `I2CS_OWN_RST;
      q.data <= `I2CS_DATA_RST;
      q.sh <= 8'h00;
      q.prev <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // Open drain: only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = q.drv.scl_oe;
  assign sda_oe_o = q.drv.sda_oe;
  assign irq_o = q.irq;
  assign wake_o = q.wake;
  assign prdata_o = q.prdata;
  assign pready_o = q.pready;
  assign pslverr_o = q.pslverr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Flag and pin checks tied to protocol milestones
  chk_hcf_done: assert property (
    rx_done |=> q.stat.transfer_complete_flag && irq_o == q.irq_en)
    else $error("byte end did not set completion flag");
  chk_hcf_low: assert property (
    q.st == ST_RX && !scl_oe_o && q.cnt != 4'h0 && active |-> !q.stat.transfer_complete_flag)
    else $error("completion flag high mid byte");
  chk_match_flag: assert property (
    addr_done && match |=> q.stat.address_match_flag && sda_oe_o)
    else $error("match did not set flag and ack");
  chk_nomatch_flag: assert property (
    addr_done && !match |=> !q.stat.address_match_flag && q.st == ST_SKIP)
    else $error("mismatch left match flag set");
  chk_busy_start: assert property (
    start_ev |=> q.stat.bus_busy_flag && q.st == ST_ADDR)
    else $error("start did not set busy");
  chk_busy_stop: assert property (
    stop_ev |=> !q.stat.bus_busy_flag ##1 (!q.stat.bus_busy_flag || start_ev))
    else $error("stop did not clear busy");
  chk_dir_select: assert property (
    scl_oe_o && rel_ev && active && !start_ev && !stop_ev |=>
    (q.st == ST_TX) == $past(q.stat.direction_select))
    else $error("wrong direction after release");
  chk_rx_ack: assert property (
    rx_done |=> sda_oe_o == !$past(q.stat.ack_to_send))
    else $error("ack level differs from ack-to-send");
  chk_srw_capture: assert property (
    addr_done && match |=> q.stat.master_read_write_flag == $past(q.sh[0]))
    else $error("read/write bit not captured");
  chk_wake_pulse: assert property (
    addr_done && match && q.stat.wake_en |=> wake_o ##1 !wake_o)
    else $error("no wake pulse on match");
  chk_ack_received_flag_sample: assert property (
    tack_rise |=> q.stat.ack_received_flag == $past(lines.sda))
    else $error("ack not sampled");
  chk_nack_release: assert property (
    tack_fall && q.stat.ack_received_flag |=> !sda_oe_o && !scl_oe_o && q.st == ST_SKIP)
    else $error("data line held after no-ack");
  chk_stretch_hold: assert property (
    scl_oe_o && !rel_ev && active && !start_ev && !stop_ev |=> scl_oe_o)
    else $error("clock released without service");

  cov_write_xfer: cover property (addr_done && match && !q.sh[0] ##[1:1000] rx_done);
  cov_read_nack: cover property (tack_fall && q.stat.ack_received_flag);
  cov_no_match: cover property (addr_done && !match);
endmodule : i2cs_top
`default_nettype wire

// ### verification/i2cs_master_model.sv
// Two-wire bus master model driving open-drain clock and data lines
`timescale 1ns/1ps
`default_nettype none
module i2cs_master_model (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  // One 160 ns wait step in system clocks; a bit takes 13 clocks (520 ns)
  localparam int HALF = 4;
  int hang_cnt = 0;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  task automatic hw();
    repeat (HALF) @(posedge clk_i);
  endtask : hw
  // Release clock; bounded wait so a stuck stretch cannot hang us
  task automatic rise();
    int n;
    n = 0;
    scl_oe_o <= 1'b0;
    @(posedge clk_i);
    while (scl_i !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) hang_cnt++;
    hw();
  endtask : rise
  // Data falls while clock is high; only this side starts frames
  task automatic start_cond();
    sda_oe_o <= 1'b0;
    hw();
    rise();
    sda_oe_o <= 1'b1;
    hw();
    scl_oe_o <= 1'b1;
    hw();
  endtask : start_cond
  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    hw();
    rise();
    sda_oe_o <= 1'b0;
    hw();
  endtask : stop_cond
  // Data changes only one wait step (HALF clocks) after the clock fell
  task automatic put_bit(input logic b);
    sda_oe_o <= ~b;
    hw();
    rise();
    scl_oe_o <= 1'b1;
    hw();
  endtask : put_bit
  task automatic get_bit(output logic b);
    sda_oe_o <= 1'b0;
    hw();
    rise();
    b = sda_i;
    scl_oe_o <= 1'b1;
    hw();
  endtask : get_bit
  task automatic put_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(ack);
  endtask : put_byte
  task automatic get_byte(input logic nak, output logic [7:0] v);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      v[i] = b;
    end
    put_bit(nak);
  endtask : get_byte
endmodule : i2cs_master_model
`default_nettype wire

// ### verification/i2cs_top_tb.sv
// Self-checking bench for the two-wire slave and its APB registers
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_regs.svh"
module i2cs_top_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic err;
  } i2cs_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, irq, wake, e, ack;
  logic d_scl_o, d_scl_oe, d_sda_o, d_sda_oe, m_scl_oe, m_sda_oe;
  logic scl_w, sda_w;
  logic [7:0] v;
  int mismatches = 0;
  int tests_run = 0;
  int irq_cnt = 0;
  int wake_cnt = 0;
  int base, wbase;
  i2cs_row_t rows [6];
  // Open-drain wires with pull-ups
  assign scl_w = ~(m_scl_oe | (d_scl_oe & ~d_scl_o));
  assign sda_w = ~(m_sda_oe | (d_sda_oe & ~d_sda_o));
  always #20 clk_i = ~clk_i;
  i2cs_top u_i2cs_top (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .scl_i(scl_w), .scl_o(d_scl_o),
    .scl_oe_o(d_scl_oe), .sda_i(sda_w), .sda_o(d_sda_o),
    .sda_oe_o(d_sda_oe), .irq_o(irq), .wake_o(wake));
  i2cs_master_model u_i2cs_master_model (.clk_i(clk_i), .scl_i(scl_w),
    .sda_i(sda_w), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe));
  // Pulses are one cycle wide, so count them every edge
  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_cnt++;
    if (wake === 1'b1) wake_cnt++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : chk
  // APB transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] rd_o, output logic er_o);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 100) mismatches++;
    rd_o = prdata;
    er_o = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic y;
    apb(1'b1, a, {24'h0, d}, x, y);
  endtask : wr
  // Read and compare only the bits under the mask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] ex);
    logic [31:0] x;
    logic y;
    apb(1'b0, a, 32'h0, x, y);
    chk(x & {24'h0, m}, {24'h0, ex});
  endtask : rd
  task automatic finish_test();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // Watchdog: many times the expected run of roughly a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    finish_test();
  end
  initial begin
    rows[0] = '{`I2CS_OFF_CTRL0, 8'he0, 1'b0};
    rows[1] = '{`I2CS_OFF_STAT, 8'h81, 1'b0};
    rows[2] = '{`I2CS_OFF_DATA, 8'h00, 1'b0};
    rows[3] = '{`I2CS_OFF_OWN, 8'h00, 1'b0};
    rows[4] = '{`I2CS_OFF_IRQEN, 8'h00, 1'b0};
    rows[5] = '{8'h14, 8'h00, 1'b1};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and one unmapped address
    foreach (rows[i]) begin
      apb(1'b0, rows[i].addr, 32'h0, r, e);
      chk(r, {24'h0, rows[i].data});
      chk({31'h0, e}, {31'h0, rows[i].err});
    end
    wr(`I2CS_OFF_CTRL0, 8'hc2);
    wr(`I2CS_OFF_OWN, 8'ha5);
    rd(`I2CS_OFF_OWN, 8'hff, 8'ha5);
    wr(`I2CS_OFF_IRQEN, 8'h01);
    // Foreign address: ignored, no acknowledge, no interrupt
    base = irq_cnt;
    u_i2cs_master_model.start_cond();
    rd(`I2CS_OFF_STAT, 8'h20, 8'h20);
    u_i2cs_master_model.put_byte(8'h20, ack);
    chk({31'h0, ack}, 32'h1);
    rd(`I2CS_OFF_STAT, 8'h40, 8'h00);
    u_i2cs_master_model.stop_cond();
    rd(`I2CS_OFF_STAT, 8'h20, 8'h00);
    chk(irq_cnt - base, 0);
    // Master writes two bytes; software refuses the second
    base = irq_cnt;
    u_i2cs_master_model.start_cond();
    u_i2cs_master_model.put_byte(8'ha4, ack);
    chk({31'h0, ack}, 32'h0);
    repeat (8) @(posedge clk_i);
    chk({31'h0, d_scl_oe}, 32'h1);
    rd(`I2CS_OFF_STAT, 8'he4, 8'he0);
    wr(`I2CS_OFF_STAT, 8'h00);
    rd(`I2CS_OFF_DATA, 8'hff, 8'h00);
    rd(`I2CS_OFF_STAT, 8'h80, 8'h00);
    chk({31'h0, d_scl_oe}, 32'h0);
    u_i2cs_master_model.put_byte(8'h3c, ack);
    chk({31'h0, ack}, 32'h0);
    rd(`I2CS_OFF_DATA, 8'hff, 8'h3c);
    wr(`I2CS_OFF_STAT, 8'h08);
    u_i2cs_master_model.put_byte(8'hc3, ack);
    chk({31'h0, ack}, 32'h1);
    rd(`I2CS_OFF_DATA, 8'hff, 8'hc3);
    wr(`I2CS_OFF_STAT, 8'h00);
    u_i2cs_master_model.stop_cond();
    rd(`I2CS_OFF_STAT, 8'h20, 8'h00);
    chk(irq_cnt - base, 3);
    // Master reads two bytes with wake-up and clock debounce on
    wr(`I2CS_OFF_CTRL0, 8'hc6);
    wr(`I2CS_OFF_STAT, 8'h02);
    base = irq_cnt;
    wbase = wake_cnt;
    u_i2cs_master_model.start_cond();
    u_i2cs_master_model.put_byte(8'ha5, ack);
    chk({31'h0, ack}, 32'h0);
    chk(wake_cnt - wbase, 1);
    rd(`I2CS_OFF_STAT, 8'h44, 8'h44);
    wr(`I2CS_OFF_STAT, 8'h14);
    wr(`I2CS_OFF_DATA, 8'h96);
    u_i2cs_master_model.get_byte(1'b0, v);
    chk({24'h0, v}, 32'h96);
    rd(`I2CS_OFF_STAT, 8'h81, 8'h80);
    wr(`I2CS_OFF_DATA, 8'h5a);
    u_i2cs_master_model.get_byte(1'b1, v);
    chk({24'h0, v}, 32'h5a);
    rd(`I2CS_OFF_STAT, 8'h01, 8'h01);
    repeat (8) @(posedge clk_i);
    chk({30'h0, d_sda_oe, d_scl_oe}, 32'h0);
    u_i2cs_master_model.stop_cond();
    rd(`I2CS_OFF_STAT, 8'h20, 8'h00);
    chk(irq_cnt - base, 3);
    chk(u_i2cs_master_model.hang_cnt, 0);
    chk({30'h0, d_scl_o, d_sda_o}, 32'h0);
    finish_test();
  end
endmodule : i2cs_top_tb
`default_nettype wire
